// ==== logic/tcp_pkg.sv ====
// Notes on behaviour
// RULE_01 - compare both values against counter each tick
// RULE_02 - compare values software owned, reset 8000h
// RULE_03 - match sets flag, pin level, interrupt
// RULE_04 - compare pin latches low during reset
// RULE_05 - flag clears: status read, then low byte
// RULE_06 - high byte write inhibits match until low
// RULE_07 - software: high, status, then low byte
// RULE_08 - pin disabled: flag only, no level
// RULE_09 - half rate matches equal, others plus one
// RULE_10 - reduced variant: second channel write only, flagless
// RULE_11 - force copies level, no flag, normal only
// RULE_12 - pulse trigger: counter FFFCh, level two, capture
// RULE_13 - pulse ends on first compare match
// RULE_14 - pulse mode: no first flag, second flags only
// RULE_15 - both selects set means PWM only
// RULE_16 - pulse and PWM: first pin no capture
// RULE_17 - software programs duration minus five counts
// RULE_18 - PWM double buffers both compare values
// RULE_19 - PWM second match reloads, sets level two
// RULE_20 - PWM sets no compare match flags
// RULE_21 - PWM second match sets first capture flag
// RULE_22 - PWM high time is value difference
// RULE_23 - clock select: /2, /4, /8, external
// RULE_24 - capture enable interrupts on either capture flag
package tcp_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CMP1_HI = 8'h0c;
  localparam logic [7:0] OFF_CMP1_LO = 8'h10;
  localparam logic [7:0] OFF_CMP2_HI = 8'h14;
  localparam logic [7:0] OFF_CMP2_LO = 8'h18;
  localparam logic [7:0] OFF_CNT_HI = 8'h1c;
  localparam logic [7:0] OFF_CNT_LO = 8'h20;
  localparam logic [7:0] OFF_CAP1_HI = 8'h24;
  localparam logic [7:0] OFF_CAP1_LO = 8'h28;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_FORCE_TWO = 4;
  localparam int C1_FORCE_ONE = 3;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_CAP_EDGE = 1;
  localparam int C1_LEVEL_ONE = 0;
  localparam int C2_PIN_EN_ONE = 7;
  localparam int C2_PIN_EN_TWO = 6;
  localparam int C2_PULSE_SEL = 5;
  localparam int C2_PWM_SEL = 4;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_EXT_EDGE = 0;
  localparam int ST_CAP_ONE = 7;
  localparam int ST_CMP_ONE = 6;
  localparam int ST_CAP_TWO = 4;
  localparam int ST_CMP_TWO = 3;

  // ----------------------------------------
  // reset and load values
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CAP_PULSE_VALUE = 16'hfffd;
  localparam logic [15:0] CMP_LATE_STEP = 16'h0001;

  // ----------------------------------------
  // timer clock select and prescaler masks
  // ----------------------------------------
  localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
  localparam logic [1:0] CLKSEL_DIV4 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV8 = 2'h2;
  localparam logic [1:0] CLKSEL_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  typedef enum logic [1:0] {TCP_MODE_NORMAL, TCP_MODE_PULSE, TCP_MODE_PWM} tcp_mode_t;

endpackage : tcp_pkg

// ==== logic/tcp_prescaler.sv ====
module tcp_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // selection
  input wire logic [1:0] clockSelect,
  input wire logic extEdgeRising,
  input wire logic extClk,
  // timer tick
  output logic timerTick
);
  import tcp_pkg::*;

  logic [2:0] divCount_r;
  logic extPrev_r;
  logic [2:0] mask;
  logic extEvent;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount_r <= 3'h0;
    end else begin
      divCount_r <= divCount_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= extClk;
    end
  end

  // the external pin is sampled, so it must run below a quarter of core_clk
  assign extEvent = extEdgeRising ? (extClk & ~extPrev_r) : (~extClk & extPrev_r);

  always_comb begin
    case (clockSelect) // see RULE_23
      CLKSEL_DIV2: mask = DIV2_MASK;
      CLKSEL_DIV4: mask = DIV4_MASK;
      CLKSEL_DIV8: mask = DIV8_MASK;
      default: mask = 3'h0;
    endcase
  end

  assign timerTick = (clockSelect == CLKSEL_EXT) ? extEvent : ((divCount_r & mask) == mask); // see RULE_23

endmodule : tcp_prescaler

// ==== logic/tcp_compare_channel.sv ====
module tcp_compare_channel #(
  parameter bit WRITE_ONLY = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // software side
  input wire logic writeHigh,
  input wire logic writeLow,
  input wire logic [7:0] writeByte,
  output logic [15:0] readValue,
  // timer side
  input wire logic pwmMode,
  input wire logic periodEnd,
  input wire logic lateMatch,
  input wire logic evalStrobe,
  input wire logic [15:0] counterValue,
  output logic matchPulse
);
  import tcp_pkg::*;

  logic [15:0] bufValue_r;
  logic [15:0] bufValue_nxt;
  logic [15:0] activeValue_r;
  logic inhibit_r;
  logic [15:0] target;

  always_comb begin
    bufValue_nxt = bufValue_r;
    if (writeHigh) begin
      bufValue_nxt[15:8] = writeByte;
    end
    if (writeLow) begin
      bufValue_nxt[7:0] = writeByte;
    end
  end

  // hardware never writes the software copy
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bufValue_r <= CMP_RESET; // see RULE_02
    end else begin
      bufValue_r <= bufValue_nxt;
    end
  end

  // in PWM the compared copy only moves at period end, so the pin never glitches
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeValue_r <= CMP_RESET;
    end else if (!pwmMode || periodEnd) begin
      activeValue_r <= bufValue_nxt; // see RULE_18
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      inhibit_r <= 1'b0;
    end else if (writeHigh) begin
      inhibit_r <= 1'b1; // see RULE_06
    end else if (writeLow) begin
      inhibit_r <= 1'b0;
    end
  end

  assign target = lateMatch ? activeValue_r + CMP_LATE_STEP : activeValue_r; // see RULE_09
  assign matchPulse = evalStrobe && !inhibit_r && (counterValue == target); // see RULE_01
  assign readValue = WRITE_ONLY ? 16'h0000 : bufValue_r; // see RULE_10

endmodule : tcp_compare_channel

// ==== logic/tcp_timer_compare.sv ====
// Decided for this implementation: the register addresses and the APB interface to the registers.
module tcp_timer_compare #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic extClk,
  input wire logic firstCapturePin,
  // joins from the rest of the timer
  input wire logic secondCaptureFlag,
  input wire logic cpuIrqMask,
  // compare output pins
  output logic compareOutputPinOne,
  output logic comparePinEnableOne,
  output logic compareOutputPinTwo,
  output logic comparePinEnableTwo,
  // interrupt request and counter view
  output logic timerIrq,
  output logic [15:0] counterValue
);
  import tcp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] controlRegOne_r;
  logic [7:0] controlRegTwo_r;
  logic [15:0] counter_r;
  logic [15:0] firstCaptureValue_r;
  logic firstCaptureFlag_r;
  logic matchFlagOne_r;
  logic matchFlagTwo_r;
  logic armCap_r;
  logic armCmpOne_r;
  logic armCmpTwo_r;
  logic capPinPrev_r;
  logic tickDelayed_r;
  logic pinOne_r;
  logic pinTwo_r;
  logic [31:0] prdata_r;
  logic timerTick;
  logic capEdge;
  logic matchOne;
  logic matchTwo;
  logic [15:0] cmpOneRead;
  logic [15:0] cmpTwoRead;
  logic accessCycle;
  logic wrEn;
  logic rdEn;
  logic [7:0] wrByte;
  logic statusRead;
  logic cmpOneLoAccess;
  logic cmpTwoLoAccess;
  logic capLoAccess;
  logic counterLoWrite;
  logic pulseMode;
  logic pwmMode;
  logic normalMode;
  logic periodEnd;
  logic reloadCounter;
  logic lateMatch;
  logic setCap;
  logic setCmpOne;
  logic setCmpTwo;
  logic [7:0] statusByte;
  logic [7:0] readByte;
  tcp_mode_t mode;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic hitAddr(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    hitAddr = (addr == offset[ADDR_W-1:0]);
  endfunction : hitAddr

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr <= OFF_CAP1_LO[ADDR_W-1:0]) && (addr[1:0] == 2'h0);
  endfunction : isMapped

  // read data is latched in the setup cycle, so every access ends with no wait state
  assign accessCycle = psel && penable;
  assign pready = accessCycle;
  assign pslverr = accessCycle && !isMapped(paddr);
  assign wrEn = accessCycle && pwrite && isMapped(paddr);
  assign rdEn = accessCycle && !pwrite && isMapped(paddr);
  assign wrByte = pwdata[7:0];
  assign statusRead = rdEn && hitAddr(paddr, OFF_STATUS);
  assign cmpOneLoAccess = accessCycle && hitAddr(paddr, OFF_CMP1_LO);
  assign cmpTwoLoAccess = accessCycle && hitAddr(paddr, OFF_CMP2_LO);
  assign capLoAccess = accessCycle && hitAddr(paddr, OFF_CAP1_LO);
  assign counterLoWrite = wrEn && hitAddr(paddr, OFF_CNT_LO);

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  always_comb begin
    if (controlRegTwo_r[C2_PWM_SEL]) begin
      mode = TCP_MODE_PWM; // see RULE_15
    end else if (controlRegTwo_r[C2_PULSE_SEL]) begin
      mode = TCP_MODE_PULSE;
    end else begin
      mode = TCP_MODE_NORMAL;
    end
  end

  assign pwmMode = (mode == TCP_MODE_PWM);
  assign pulseMode = (mode == TCP_MODE_PULSE);
  assign normalMode = (mode == TCP_MODE_NORMAL);
  assign lateMatch = (controlRegTwo_r[C2_CLK_SEL_LO +: 2] != CLKSEL_DIV2); // see RULE_09

  // ----------------------------------------
  // timer clock and counter
  // ----------------------------------------
  tcp_prescaler prescaler (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clockSelect(controlRegTwo_r[C2_CLK_SEL_LO +: 2]),
    .extEdgeRising(controlRegTwo_r[C2_EXT_EDGE]),
    .extClk(extClk),
    .timerTick(timerTick)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      capPinPrev_r <= 1'b0;
    end else begin
      capPinPrev_r <= firstCapturePin;
    end
  end

  assign capEdge = controlRegOne_r[C1_CAP_EDGE] ? (firstCapturePin & ~capPinPrev_r)
    : (~firstCapturePin & capPinPrev_r);
  assign periodEnd = pwmMode && matchTwo;
  assign reloadCounter = counterLoWrite || (pulseMode && capEdge) || periodEnd; // see RULE_12

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_r <= CNT_RELOAD;
    end else if (reloadCounter) begin
      counter_r <= CNT_RELOAD; // see RULE_19
    end else if (timerTick) begin
      counter_r <= counter_r + 16'h0001;
    end
  end

  // compare only once per new count value, one cycle after the tick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickDelayed_r <= 1'b0;
    end else begin
      tickDelayed_r <= timerTick && !reloadCounter;
    end
  end

  assign counterValue = counter_r;

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  tcp_compare_channel #(.WRITE_ONLY(1'b0)) channelOne (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .writeHigh(wrEn && hitAddr(paddr, OFF_CMP1_HI)),
    .writeLow(wrEn && hitAddr(paddr, OFF_CMP1_LO)),
    .writeByte(wrByte),
    .readValue(cmpOneRead),
    .pwmMode(pwmMode),
    .periodEnd(periodEnd),
    .lateMatch(lateMatch),
    .evalStrobe(tickDelayed_r),
    .counterValue(counter_r),
    .matchPulse(matchOne)
  );

  tcp_compare_channel #(.WRITE_ONLY(REDUCED_VARIANT)) channelTwo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .writeHigh(wrEn && hitAddr(paddr, OFF_CMP2_HI)),
    .writeLow(wrEn && hitAddr(paddr, OFF_CMP2_LO)),
    .writeByte(wrByte),
    .readValue(cmpTwoRead),
    .pwmMode(pwmMode),
    .periodEnd(periodEnd),
    .lateMatch(lateMatch),
    .evalStrobe(tickDelayed_r),
    .counterValue(counter_r),
    .matchPulse(matchTwo)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      controlRegOne_r <= CTRL_RESET;
    end else if (wrEn && hitAddr(paddr, OFF_CTRL1)) begin
      controlRegOne_r <= wrByte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      controlRegTwo_r <= CTRL_RESET;
    end else if (wrEn && hitAddr(paddr, OFF_CTRL2)) begin
      controlRegTwo_r <= wrByte;
    end
  end

  // ----------------------------------------
  // flags: set wins over the two-step clear
  // ----------------------------------------
  assign setCmpOne = matchOne && normalMode; // see RULE_14
  assign setCmpTwo = matchTwo && !pwmMode && !REDUCED_VARIANT; // see RULE_20
  assign setCap = (normalMode && capEdge) || (pulseMode && capEdge) || periodEnd; // see RULE_21

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      armCmpOne_r <= 1'b0;
      armCmpTwo_r <= 1'b0;
      armCap_r <= 1'b0;
    end else begin
      armCmpOne_r <= statusRead ? matchFlagOne_r : (armCmpOne_r && !cmpOneLoAccess); // see RULE_05
      armCmpTwo_r <= statusRead ? matchFlagTwo_r : (armCmpTwo_r && !cmpTwoLoAccess);
      armCap_r <= statusRead ? firstCaptureFlag_r : (armCap_r && !capLoAccess);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      matchFlagOne_r <= 1'b0;
    end else if (setCmpOne) begin
      matchFlagOne_r <= 1'b1; // see RULE_03
    end else if (armCmpOne_r && cmpOneLoAccess) begin
      matchFlagOne_r <= 1'b0; // see RULE_05
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      matchFlagTwo_r <= 1'b0;
    end else if (setCmpTwo) begin
      matchFlagTwo_r <= 1'b1; // see RULE_03
    end else if (armCmpTwo_r && cmpTwoLoAccess) begin
      matchFlagTwo_r <= 1'b0; // see RULE_05
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstCaptureFlag_r <= 1'b0;
    end else if (setCap) begin
      firstCaptureFlag_r <= 1'b1;
    end else if (armCap_r && capLoAccess) begin
      firstCaptureFlag_r <= 1'b0;
    end
  end

  // first capture pin only captures the counter in normal mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstCaptureValue_r <= 16'h0000;
    end else if (pulseMode && capEdge) begin
      firstCaptureValue_r <= CAP_PULSE_VALUE; // see RULE_12
    end else if (normalMode && capEdge) begin
      firstCaptureValue_r <= counter_r; // see RULE_16
    end
  end

  assign timerIrq = !cpuIrqMask && ((controlRegOne_r[C1_CMP_IRQ_EN] && (matchFlagOne_r || matchFlagTwo_r))
    || (controlRegOne_r[C1_CAP_IRQ_EN] && (firstCaptureFlag_r || secondCaptureFlag))); // see RULE_24

  // ----------------------------------------
  // compare output pins
  // ----------------------------------------
  assign comparePinEnableOne = controlRegTwo_r[C2_PIN_EN_ONE]; // see RULE_08
  assign comparePinEnableTwo = controlRegTwo_r[C2_PIN_EN_TWO];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOne_r <= 1'b0; // see RULE_04
    end else if (comparePinEnableOne) begin
      case (mode)
        TCP_MODE_NORMAL: begin
          if (matchOne || controlRegOne_r[C1_FORCE_ONE]) begin
            pinOne_r <= controlRegOne_r[C1_LEVEL_ONE]; // see RULE_11
          end
        end
        TCP_MODE_PULSE: begin
          if (capEdge) begin
            pinOne_r <= controlRegOne_r[C1_LEVEL_TWO]; // see RULE_12
          end else if (matchOne) begin
            pinOne_r <= controlRegOne_r[C1_LEVEL_ONE]; // see RULE_13
          end
        end
        TCP_MODE_PWM: begin
          // equal levels give a steady pin; high time is the value difference
          if (matchTwo) begin
            pinOne_r <= controlRegOne_r[C1_LEVEL_TWO]; // see RULE_19 see RULE_22
          end else if (matchOne) begin
            pinOne_r <= controlRegOne_r[C1_LEVEL_ONE]; // see RULE_22
          end
        end
        default: pinOne_r <= pinOne_r;
      endcase
    end
  end

  // second pin is idle outside normal mode since its level serves the first pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinTwo_r <= 1'b0; // see RULE_04
    end else if (comparePinEnableTwo && normalMode && (matchTwo || controlRegOne_r[C1_FORCE_TWO])) begin
      pinTwo_r <= controlRegOne_r[C1_LEVEL_TWO]; // see RULE_14 see RULE_11
    end
  end

  assign compareOutputPinOne = pinOne_r;
  assign compareOutputPinTwo = pinTwo_r;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_CAP_ONE] = firstCaptureFlag_r;
    statusByte[ST_CMP_ONE] = matchFlagOne_r;
    statusByte[ST_CAP_TWO] = secondCaptureFlag;
    statusByte[ST_CMP_TWO] = matchFlagTwo_r;
  end

  always_comb begin
    case (paddr)
      OFF_CTRL1: readByte = controlRegOne_r;
      OFF_CTRL2: readByte = controlRegTwo_r;
      OFF_STATUS: readByte = statusByte;
      OFF_CMP1_HI: readByte = cmpOneRead[15:8];
      OFF_CMP1_LO: readByte = cmpOneRead[7:0];
      OFF_CMP2_HI: readByte = cmpTwoRead[15:8];
      OFF_CMP2_LO: readByte = cmpTwoRead[7:0];
      OFF_CNT_HI: readByte = counter_r[15:8];
      OFF_CNT_LO: readByte = counter_r[7:0];
      OFF_CAP1_HI: readByte = firstCaptureValue_r[15:8];
      OFF_CAP1_LO: readByte = firstCaptureValue_r[7:0];
      default: readByte = 8'h00;
    endcase
  end

  // latched in setup; a flag set during access shows on the next status read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {24'h000000, readByte};
    end
  end

  assign prdata = prdata_r;

endmodule : tcp_timer_compare

// ==== testbench/tcp_sva.sv ====
module tcp_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // timer side
  input wire logic secondCaptureFlag,
  input wire logic cpuIrqMask,
  input wire logic compareOutputPinOne,
  input wire logic compareOutputPinTwo,
  input wire logic comparePinEnableOne,
  input wire logic comparePinEnableTwo,
  input wire logic timerIrq,
  input wire logic [15:0] counterValue
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcp_pkg::*;
  logic [7:0] ctrlOne_r;
  logic [7:0] ctrlTwo_r;
  // ----------------------------------------
  // control shadows, rebuilt from apb writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) ctrlOne_r <= CTRL_RESET;
    else if (psel && penable && pwrite && paddr == OFF_CTRL1) ctrlOne_r <= pwdata[7:0];
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) ctrlTwo_r <= CTRL_RESET;
    else if (psel && penable && pwrite && paddr == OFF_CTRL2) ctrlTwo_r <= pwdata[7:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_access;
    psel && penable;
  endsequence
  a_apb_answer: assert property (s_access |-> pready && (paddr <= OFF_CAP1_LO || pslverr))
    else $error("apb answer wrong");
  a_pin_reset: assert property ($rose(reset_n) |-> !compareOutputPinOne && !compareOutputPinTwo)
    else $error("pin not low after reset");
  a_irq_masked: assert property (cpuIrqMask |-> !timerIrq)
    else $error("irq while masked");
  a_cap_irq: assert property (ctrlOne_r[7] && secondCaptureFlag && !cpuIrqMask |-> timerIrq)
    else $error("capture irq missing");
  a_enable_copy: assert property (comparePinEnableOne == ctrlTwo_r[7] && comparePinEnableTwo == ctrlTwo_r[6])
    else $error("pin enable wrong");
  a_pin_hold: assert property (!comparePinEnableOne |=> $stable(compareOutputPinOne))
    else $error("disabled pin moved");
  a_force_copy: assert property (ctrlOne_r[3] && ctrlTwo_r[5:4] == 2'h0 && comparePinEnableOne
    |=> compareOutputPinOne == $past(ctrlOne_r[0]))
    else $error("force level not copied");
  a_reload_value: assert property (counterValue != $past(counterValue)
    && counterValue != $past(counterValue) + 16'h1 |-> counterValue == CNT_RELOAD)
    else $error("counter jump not to reload");
endmodule : tcp_sva

bind tcp_timer_compare tcp_sva chk_i (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .secondCaptureFlag, .cpuIrqMask, .compareOutputPinOne, .compareOutputPinTwo,
  .comparePinEnableOne, .comparePinEnableTwo, .timerIrq, .counterValue);

// ==== testbench/tcp_pin_load.sv ====
module tcp_pin_load (
  // pin side
  input wire logic core_clk,
  input wire logic pinLevel,
  input wire logic pinEnable,
  // observed waveform
  output logic padLevel,
  output int highLen,
  output int pulses
);
  timeunit 1ns;
  timeprecision 100ps;
  int run = 0;
  initial highLen = 0;
  initial pulses = 0;
  // pull-up holds a released pad high
  assign padLevel = pinEnable ? pinLevel : 1'h1;
  always @(posedge core_clk) begin
    if (padLevel) run <= run + 1;
    else if (run != 0) begin
      highLen <= run;
      pulses <= pulses + 1;
      run <= 0;
    end
  end
endmodule : tcp_pin_load

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tcp_pkg::*;
  logic core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic extClk = 1'h0, firstCapturePin = 1'h0, secondCaptureFlag = 1'h0, cpuIrqMask = 1'h0;
  logic [7:0] paddr = 8'h0, rd;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h8c44e42c;
  logic pready, pslverr, compareOutputPinOne, comparePinEnableOne, compareOutputPinTwo, comparePinEnableTwo;
  logic timerIrq, pad;
  logic [15:0] counterValue;
  int n_mismatch = 0, checked = 0, n, highLen, pulses;
  tcp_timer_compare dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .extClk, .firstCapturePin, .secondCaptureFlag, .cpuIrqMask, .compareOutputPinOne,
    .comparePinEnableOne, .compareOutputPinTwo, .comparePinEnableTwo, .timerIrq, .counterValue);
  tcp_pin_load load (.core_clk, .pinLevel(compareOutputPinOne), .pinEnable(comparePinEnableOne),
    .padLevel(pad), .highLen, .pulses);
  initial forever #12.5 core_clk = ~core_clk;
  // external tick every 10 cycles, under the quarter-rate limit
  always begin
    repeat (5) @(posedge core_clk);
    extClk <= ~extClk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d = 8'h0);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_pin(input logic v);
    for (n = 0; compareOutputPinOne !== v && n < 4000; n++) @(posedge core_clk);
  endtask : wait_pin
  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; counterValue !== v && i < 4000; i++) @(posedge core_clk);
  endtask : wait_cnt
  task automatic wait_pulses(input int k);
    n = pulses + k;
    for (int i = 0; pulses < n && i < 4000; i++) @(posedge core_clk);
    @(posedge core_clk);
  endtask : wait_pulses
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'h1;
    apb(0, OFF_CMP1_HI);
    chk(rd, 8'h80);
    chk({compareOutputPinOne, compareOutputPinTwo}, 2'h0);
    apb(0, 8'h3c);
    chk({err, rd}, 9'h100);
    repeat (3) begin
      lfsr = nxt(lfsr);
      apb(1, OFF_CMP2_HI, lfsr[15:8]);
      apb(1, OFF_CMP2_LO, lfsr[7:0]);
      apb(0, OFF_CMP2_HI);
      chk(rd, lfsr[15:8]);
      apb(0, OFF_CMP2_LO);
      chk(rd, lfsr[7:0]);
    end
    $display("end of test reset and access");
    for (int s = 0; s < 4; s++) begin
      apb(1, OFF_CTRL1, 8'h40 | 8'(~s & 1));
      apb(1, OFF_CTRL2, 8'h81 | 8'(s << 2));
      apb(1, OFF_CMP1_HI, 8'h00);
      apb(1, OFF_CMP1_LO, 8'h08);
      apb(1, OFF_CNT_LO);
      wait_cnt(16'h0008);
      wait_pin(1'(~s & 1));
      chk(n, s == 0 ? 1 : (s == 3 ? 10 : 2 << s) + 1);
      chk(timerIrq, 1'h1);
      apb(0, OFF_CMP1_LO);
      chk(timerIrq, 1'h1);
      apb(0, OFF_STATUS);
      chk(rd[ST_CMP_ONE], 1'h1);
      apb(0, OFF_CMP1_LO);
      apb(0, OFF_CMP2_LO);
      chk(timerIrq, 1'h0);
    end
    $display("end of test match timing");
    apb(1, OFF_CTRL2, 8'h80);
    apb(1, OFF_CTRL1, 8'h41);
    apb(1, OFF_CMP1_HI, 8'h00);
    apb(1, OFF_CNT_LO);
    repeat (60) @(posedge core_clk);
    apb(0, OFF_STATUS);
    chk({compareOutputPinOne, rd[ST_CMP_ONE]}, 2'h0);
    apb(1, OFF_CMP1_LO, 8'h08);
    apb(1, OFF_CNT_LO);
    wait_pin(1'h1);
    apb(0, OFF_STATUS);
    chk(rd[ST_CMP_ONE], 1'h1);
    apb(0, OFF_CMP1_LO);
    apb(1, OFF_CTRL2, 8'h00);
    apb(1, OFF_CTRL1, 8'h00);
    apb(1, OFF_CNT_LO);
    repeat (60) @(posedge core_clk);
    apb(0, OFF_STATUS);
    chk({compareOutputPinOne, pad, rd[ST_CMP_ONE]}, 3'h7);
    apb(0, OFF_CMP1_LO);
    apb(1, OFF_CTRL2, 8'h80);
    apb(1, OFF_CTRL1, 8'h08);
    apb(0, OFF_STATUS);
    chk({compareOutputPinOne, rd[ST_CMP_ONE]}, 2'h0);
    $display("end of test inhibit, disable, force");
    apb(1, OFF_CTRL1, 8'h06);
    apb(1, OFF_CTRL2, 8'ha0);
    apb(1, OFF_CMP1_LO, 8'h10);
    firstCapturePin <= 1'h1;
    wait_pin(1'h1);
    wait_pin(1'h0);
    @(posedge core_clk);
    chk(highLen >= (16 + 5) * 2 - 2 && highLen <= (16 + 5) * 2 + 2, 1'h1);
    apb(0, OFF_CAP1_HI);
    chk(rd, 8'hff);
    apb(0, OFF_CAP1_LO);
    chk(rd, 8'hfd);
    apb(0, OFF_STATUS);
    chk({rd[ST_CAP_ONE], rd[ST_CMP_ONE]}, 2'h2);
    apb(0, OFF_CAP1_LO);
    $display("end of test single pulse");
    apb(1, OFF_CMP2_HI, 8'h00);
    apb(1, OFF_CMP2_LO, 8'h20);
    apb(1, OFF_CTRL1, 8'h81);
    apb(1, OFF_CTRL2, 8'hb0);
    apb(1, OFF_CNT_LO);
    wait_pulses(2);
    chk(highLen, (32 - 16) * 2);
    apb(1, OFF_CMP1_HI, 8'h00);
    apb(1, OFF_CMP1_LO, 8'h18);
    wait_pulses(2);
    chk(highLen, (32 - 24) * 2);
    apb(0, OFF_STATUS);
    chk({timerIrq, rd[ST_CAP_ONE], rd[ST_CMP_ONE], rd[ST_CMP_TWO]}, 4'hc);
    apb(1, OFF_CTRL2, 8'h80);
    apb(0, OFF_STATUS);
    apb(0, OFF_CAP1_LO);
    secondCaptureFlag <= 1'h1;
    apb(0, OFF_STATUS);
    chk({timerIrq, rd[ST_CAP_TWO], rd[ST_CAP_ONE]}, 3'h6);
    cpuIrqMask <= 1'h1;
    apb(0, OFF_STATUS);
    chk(timerIrq, 1'h0);
    $display("end of test pwm and interrupts");
    end_of_test();
  end
  // watchdog, run needs about a thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
